// ---- logic/tmo_mem_access.sv ----
// nonvolatile memory access control of the tag: read, block program, lock and selection
// assumes commands arrive decoded and synchronous to mclk_in, one at a time
// How it works
// - array split: 1 Kbit user region, 320 bit control region
// - pages of 128 bits made of four 32 bit blocks, except the manufacturer page of two blocks
// - every accepted program command writes exactly one block; refused ones write none
// - bit 31 of block 3 locks its page against programming
// - reads are always allowed, lock or not
// - manufacturer page writable only before die separation
// - identifier page at control page zero and symbolic address zero
// - default layout: 96 bit identifier plus 8 bit format code
// - identifier msb sits in top byte of block 2
// - format code sits in low byte of block 3
// - family code compare, 00h selects unconditionally
// - short commands address the identifier page implicitly
// - default arbitration starts at format code then identifier
// - arbitration can run on into user pages
// - group selection gates arbitration; read and program are gated by neither selection nor arbitration
// - locked identifier page is fixed forever
// - programming a locked page reports page locked in status byte
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.svh"
module tmo_mem_access #(
    parameter int PROG_CYCLES = `TMO_PROG_CYC
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic [1:0] cmd_in,
    input wire logic short_cmd_in,
    input wire logic ctrl_region_in,
    input wire logic [2:0] page_in,
    input wire logic [1:0] block_in,
    input wire logic [31:0] wdata_in,
    input wire logic [7:0] application_family_code_in,
    input wire logic group_selected_in,
    input wire logic sawn_in,
    output logic done_out,
    output logic [31:0] rdata_out,
    output logic [7:0] communication_status_byte_out,
    output logic selected_out,
    output logic arb_valid_out,
    output logic [31:0] arb_word_out,
    output logic prog_busy_out
);
    typedef struct packed {
        tmo_pkg::tmo_state_t st;
        tmo_pkg::tmo_cmd_t cmd;
        logic [5:0] idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [7:0] stat;
        logic sel;
        logic arb;
        logic [31:0] arbw;
        logic [5:0] arb_idx;
        logic [23:0] cnt;
        logic done;
    } tmo_regs_t;

    tmo_regs_t q_r;
    tmo_regs_t q_nxt;
    logic [31:0] mem_r [0:41];
    logic rst_s1_r;
    logic rst_n_r;
    logic [5:0] idx_w;
    logic addr_ok_w;
    logic fam_ok_w;
    logic eff_ctrl_w;
    logic [2:0] eff_page_w;
    logic [1:0] eff_block_w;
    logic page_locked_w;
    logic mfr_block_w;
    logic wr_en_w;

    localparam logic [23:0] PROG_LAST = 24'(PROG_CYCLES - 1);

    // reset release through two flops
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // short commands and symbolic address zero both resolve to the identifier page
    always_comb begin
        if (short_cmd_in) begin
            eff_ctrl_w = 1'b1;
            eff_page_w = `TMO_SYM_ID;
        end else begin
            eff_ctrl_w = ctrl_region_in;
            eff_page_w = page_in;
        end
        eff_block_w = block_in;
    end

    tmo_addr_map u_map (
        .ctrl_in(eff_ctrl_w),
        .page_in(eff_page_w),
        .block_in(eff_block_w),
        .index_out(idx_w),
        .valid_out(addr_ok_w)
    );

    // identifier page block 3 holds the family code in bits 15:8 and format code in 7:0
    tmo_family_match u_fam (
        .rx_code_in(application_family_code_in),
        .stored_code_in(mem_r[32 + 3][15:8]),
        .match_out(fam_ok_w)
    );

    // the lock bit of the addressed page is bit 31 of its top block
    always_comb begin
        if ({idx_w[5:2], `TMO_LOCK_BLOCK} > `TMO_LAST_WORD) begin
            // the manufacturer half page has no lock word, so it reads as open
            page_locked_w = 1'b0;
        end else begin
            page_locked_w = mem_r[{idx_w[5:2], `TMO_LOCK_BLOCK}][`TMO_LOCK_BIT];
        end
        mfr_block_w = eff_ctrl_w && (eff_page_w == `TMO_MFR_PAGE);
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.done = 1'b0;
        case (q_r.st)
            tmo_pkg::TMO_IDLE: begin
                if (cmd_valid_in) begin
                    q_nxt.idx = idx_w;
                    q_nxt.wd = wdata_in;
                    q_nxt.cmd = tmo_pkg::tmo_cmd_t'(cmd_in);
                    if (cmd_in == tmo_pkg::TMO_CMD_FAM) begin
                        q_nxt.sel = fam_ok_w;
                        q_nxt.stat = `TMO_ST_OK;
                        q_nxt.st = tmo_pkg::TMO_DONE;
                    end else if (!addr_ok_w) begin
                        q_nxt.stat = `TMO_ST_BADADDR;
                        q_nxt.st = tmo_pkg::TMO_DONE;
                    end else if (cmd_in == tmo_pkg::TMO_CMD_ARB) begin
                        // arbitration joins only tags picked by a prior group selection
                        q_nxt.arb = group_selected_in;
                        // default start: format code block of the identifier page
                        q_nxt.arb_idx = short_cmd_in ? 6'(32 + 3) : idx_w;
                        q_nxt.stat = `TMO_ST_OK;
                        q_nxt.st = tmo_pkg::TMO_READ;
                    end else if (cmd_in == tmo_pkg::TMO_CMD_READ) begin
                        q_nxt.stat = `TMO_ST_OK;
                        q_nxt.st = tmo_pkg::TMO_READ;
                    end else if (page_locked_w || (mfr_block_w && sawn_in)) begin
                        q_nxt.stat = `TMO_ST_LOCKED;
                        q_nxt.st = tmo_pkg::TMO_DONE;
                    end else begin
                        q_nxt.stat = `TMO_ST_OK;
                        q_nxt.cnt = 24'h000000;
                        q_nxt.st = tmo_pkg::TMO_PROG;
                    end
                end
            end
            tmo_pkg::TMO_READ: begin
                q_nxt.rd = mem_r[q_r.idx];
                if (q_r.cmd == tmo_pkg::TMO_CMD_ARB) begin
                    q_nxt.arbw = mem_r[q_r.arb_idx];
                    // walking downward runs from identifier into user pages 7, 6 ...
                    q_nxt.arb_idx = (q_r.arb_idx == 6'h20) ? 6'h1f : q_r.arb_idx - 6'h01;
                end
                q_nxt.st = tmo_pkg::TMO_DONE;
            end
            tmo_pkg::TMO_PROG: begin
                q_nxt.st = tmo_pkg::TMO_WAIT;
            end
            tmo_pkg::TMO_WAIT: begin
                if (q_r.cnt >= PROG_LAST) begin
                    q_nxt.st = tmo_pkg::TMO_DONE;
                end else begin
                    q_nxt.cnt = q_r.cnt + 24'h000001;
                end
            end
            tmo_pkg::TMO_DONE: begin
                q_nxt.done = 1'b1;
                q_nxt.st = tmo_pkg::TMO_IDLE;
            end
            default: begin
                q_nxt.st = tmo_pkg::TMO_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            q_r <= '0;
        end else if (ce_in) begin
            q_r <= q_nxt;
        end
    end

    // one block written per program command
    assign wr_en_w = ce_in && (q_r.st == tmo_pkg::TMO_PROG);

    // nonvolatile array: user words 0..31, control words 32..41
    always_ff @(posedge mclk_in) begin
        if (wr_en_w) begin
            mem_r[q_r.idx] <= q_r.wd;
        end
    end

    assign cmd_ready_out = (q_r.st == tmo_pkg::TMO_IDLE);
    assign done_out = q_r.done;
    assign rdata_out = q_r.rd;
    assign communication_status_byte_out = q_r.stat;
    assign selected_out = q_r.sel;
    assign arb_valid_out = q_r.arb;
    assign arb_word_out = q_r.arbw;
    assign prog_busy_out = (q_r.st == tmo_pkg::TMO_PROG) || (q_r.st == tmo_pkg::TMO_WAIT);

    // id field msb and format code positions within the identifier page
    logic [7:0] id_msb_byte_w;
    logic [7:0] fmt_code_w;
    assign id_msb_byte_w = mem_r[32 + 2][31:24];
    assign fmt_code_w = mem_r[32 + 3][7:0];

    property p_lock_refuse;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_PROG
            && addr_ok_w && page_locked_w) |=> (q_r.stat == `TMO_ST_LOCKED && q_r.st != tmo_pkg::TMO_PROG);
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked page programmed");

    property p_read_ok;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_READ && addr_ok_w)
            |=> q_r.st == tmo_pkg::TMO_READ && q_r.stat == `TMO_ST_OK;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("read refused");

    property p_wild;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_FAM
            && application_family_code_in == 8'h00) |=> q_r.sel;
    endproperty
    a_wild: assert property (p_wild) else $error("wildcard not selected");

    property p_one_write;
        @(posedge mclk_in) disable iff (!rst_n_r)
        wr_en_w |=> !wr_en_w;
    endproperty
    a_one_write: assert property (p_one_write) else $error("more than one block write");

    property p_mfr;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_PROG
            && addr_ok_w && mfr_block_w && sawn_in) |=> q_r.stat == `TMO_ST_LOCKED;
    endproperty
    a_mfr: assert property (p_mfr) else $error("manufacturer page writable after sawing");

    property p_short;
        @(posedge mclk_in) disable iff (!rst_n_r)
        short_cmd_in |-> idx_w[5:2] == 4'h8;
    endproperty
    a_short: assert property (p_short) else $error("short command misses identifier page");

    property p_arb_gate;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_ARB && addr_ok_w)
            |=> q_r.arb == $past(group_selected_in);
    endproperty
    a_arb_gate: assert property (p_arb_gate) else $error("arbitration ignores group selection");

    property p_done;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_READ) ##1 ce_in |=> q_r.done;
    endproperty
    a_done: assert property (p_done) else $error("read did not complete");

    property p_id_msb;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_READ && q_r.cmd == tmo_pkg::TMO_CMD_READ
            && q_r.idx == `TMO_ID_MSB_WORD) |=> q_r.rd[31:24] == $past(id_msb_byte_w);
    endproperty
    a_id_msb: assert property (p_id_msb) else $error("identifier top byte misplaced");

    property p_fmt_arb;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_READ && q_r.cmd == tmo_pkg::TMO_CMD_ARB
            && q_r.arb_idx == `TMO_ID_FMT_WORD) |=> q_r.arbw[`TMO_FMT_LSB +: 8] == $past(fmt_code_w);
    endproperty
    a_fmt_arb: assert property (p_fmt_arb) else $error("arbitration does not open with format code");

    property p_bad_addr;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in != tmo_pkg::TMO_CMD_FAM
            && !addr_ok_w) |=> q_r.stat == `TMO_ST_BADADDR && q_r.st == tmo_pkg::TMO_DONE;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("address beyond control region accepted");

    property p_prog_start;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_PROG
            && addr_ok_w && !page_locked_w && !(mfr_block_w && sawn_in))
            |=> q_r.st == tmo_pkg::TMO_PROG && q_r.stat == `TMO_ST_OK;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("open block not programmed");

    property p_prog_wait;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_PROG) |=> q_r.st == tmo_pkg::TMO_WAIT && q_r.cnt == 24'h000000;
    endproperty
    a_prog_wait: assert property (p_prog_wait) else $error("program time not started");

    property p_write_lands;
        @(posedge mclk_in) disable iff (!rst_n_r)
        wr_en_w |=> mem_r[$past(q_r.idx)] == $past(q_r.wd);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("block write lost");

    property p_fam_miss;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in && cmd_in == tmo_pkg::TMO_CMD_FAM
            && application_family_code_in != `TMO_WILDCARD
            && application_family_code_in != mem_r[32 + 3][15:8]) |=> !q_r.sel;
    endproperty
    a_fam_miss: assert property (p_fam_miss) else $error("foreign family code selected");

    property p_sel_hold;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_IDLE && cmd_valid_in
            && (cmd_in == tmo_pkg::TMO_CMD_READ || cmd_in == tmo_pkg::TMO_CMD_PROG))
            |=> q_r.arb == $past(q_r.arb) && q_r.sel == $past(q_r.sel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("read or program changed selection");

    property p_arb_walk;
        @(posedge mclk_in) disable iff (!rst_n_r)
        (ce_in && q_r.st == tmo_pkg::TMO_READ && q_r.cmd == tmo_pkg::TMO_CMD_ARB) |=> q_r.arb_idx == $past(q_r.arb_idx) - 6'h01;
    endproperty
    a_arb_walk: assert property (p_arb_walk) else $error("arbitration pointer did not step down");

    property p_ce_hold;
        @(posedge mclk_in) disable iff (!rst_n_r)
        !ce_in |=> q_r == $past(q_r);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved while enable low");
endmodule : tmo_mem_access
`default_nettype wire

// ---- inc/tmo_map.svh ----
// constants of the tag memory access block: geometry, layout and status codes
// assumes inclusion by bare name from design files
`ifndef TMO_MAP_SVH
`define TMO_MAP_SVH
`define TMO_USER_PAGES 8
`define TMO_CTRL_BLOCKS 10
`define TMO_BLOCK_BITS 32
`define TMO_BLOCKS_PER_PAGE 4
`define TMO_ID_PAGE 3'h0
`define TMO_SYM_ID 3'h0
`define TMO_MFR_PAGE 3'h2
`define TMO_LOCK_BIT 31
`define TMO_LOCK_BLOCK 2'h3
`define TMO_FMT_BLOCK 2'h3
`define TMO_FMT_LSB 0
`define TMO_ID_MSB_BLOCK 2'h2
`define TMO_ID_MSB_WORD 6'h22
`define TMO_ID_FMT_WORD 6'h23
`define TMO_LAST_WORD 6'h29
`define TMO_WILDCARD 8'h00
`define TMO_ST_OK 8'h00
`define TMO_ST_LOCKED 8'h04
`define TMO_ST_BADADDR 8'h08
`define TMO_PROG_MS 9
`define TMO_OSC_KHZ 40000
`define TMO_PROG_CYC (`TMO_PROG_MS * `TMO_OSC_KHZ)
`endif

// ---- inc/tmo_pkg.sv ----
// types of the tag memory access block
// assumes nothing beyond the map header
package tmo_pkg;
    typedef enum logic [2:0] {
        TMO_IDLE = 3'b000,
        TMO_READ = 3'b001,
        TMO_PROG = 3'b010,
        TMO_WAIT = 3'b011,
        TMO_DONE = 3'b100
    } tmo_state_t;
    typedef enum logic [1:0] {
        TMO_CMD_READ = 2'b00,
        TMO_CMD_PROG = 2'b01,
        TMO_CMD_ARB = 2'b10,
        TMO_CMD_FAM = 2'b11
    } tmo_cmd_t;
endpackage : tmo_pkg

// ---- logic/tmo_family_match.sv ----
// application family selection compare
// assumes stored code comes from the identifier page
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.svh"
module tmo_family_match (
    input wire logic [7:0] rx_code_in,
    input wire logic [7:0] stored_code_in,
    output logic match_out
);
    assign match_out = (rx_code_in == `TMO_WILDCARD) || (rx_code_in == stored_code_in);
endmodule : tmo_family_match
`default_nettype wire

// ---- logic/tmo_addr_map.sv ----
// maps region, page and block to a flat word index
// assumes user pages 0..7 then control pages 0..2 (page 2 half size)
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.svh"
module tmo_addr_map (
    input wire logic ctrl_in,
    input wire logic [2:0] page_in,
    input wire logic [1:0] block_in,
    output logic [5:0] index_out,
    output logic valid_out
);
    always_comb begin
        index_out = {ctrl_in, 5'h00} + {1'b0, page_in, block_in};
        if (ctrl_in) begin
            valid_out = ({1'b0, page_in, block_in} < 6'(`TMO_CTRL_BLOCKS));
        end else begin
            valid_out = 1'b1;
        end
    end
endmodule : tmo_addr_map
`default_nettype wire

// ---- verif/tmo_reader_model.sv ----
// reader-side command source for the tag memory access block
// assumes the block answers each accepted command with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module tmo_reader_model (
    input wire logic mclk_in,
    input wire logic cmd_ready_in,
    input wire logic done_in,
    input wire logic [31:0] rdata_in,
    input wire logic [7:0] status_in,
    output logic cmd_valid_out,
    output logic [1:0] cmd_out,
    output logic short_cmd_out,
    output logic ctrl_region_out,
    output logic [2:0] page_out,
    output logic [1:0] block_out,
    output logic [31:0] wdata_out,
    output logic [7:0] family_out,
    output logic timeout_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = 2'h0;
        short_cmd_out = 1'b0;
        ctrl_region_out = 1'b0;
        page_out = 3'h0;
        block_out = 2'h0;
        wdata_out = 32'h0;
        family_out = 8'h0;
        timeout_out = 1'b0;
    end
    // one command, one block: a program request carries exactly one 32 bit word
    task automatic issue(input tmo_pkg::tmo_cmd_t c, input logic s, input logic ctl, input logic [2:0] p,
                         input logic [1:0] b, input logic [31:0] wd, input logic [7:0] fam,
                         output logic [31:0] rd, output logic [7:0] st);
        int n;
        n = 0;
        @(negedge mclk_in);
        while (cmd_ready_in !== 1'b1 && n < 50) begin
            @(negedge mclk_in);
            n++;
        end
        if (cmd_ready_in !== 1'b1) begin
            timeout_out = 1'b1;
        end
        cmd_out = c;
        short_cmd_out = s;
        ctrl_region_out = ctl;
        page_out = p;
        block_out = b;
        wdata_out = wd;
        family_out = fam;
        cmd_valid_out = 1'b1;
        @(posedge mclk_in);
        @(negedge mclk_in);
        // released qualifiers no longer show the request
        cmd_valid_out = 1'b0;
        wdata_out = ~wd;
        family_out = ~fam;
        block_out = ~b;
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (done_in !== 1'b1 && n < 50);
        if (done_in !== 1'b1) begin
            timeout_out = 1'b1;
        end
        rd = rdata_in;
        st = status_in;
    endtask : issue
endmodule : tmo_reader_model
`default_nettype wire

// ---- verif/tb_tmo_mem_access.sv ----
// self-checking bench of the tag memory access block
// assumes a shortened program time and a reader model issuing the commands
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.svh"
module tb_tmo_mem_access;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic group_selected_in = 1'b1;
    logic sawn_in = 1'b0;
    wire logic cmd_valid, cmd_ready, short_cmd, ctrl_region, done, selected, arb_valid, prog_busy, tmo;
    wire logic [1:0] cmd, block;
    wire logic [2:0] page;
    wire logic [31:0] wdata, rdata, arb_word;
    wire logic [7:0] fam, status;
    int fail_count = 0;
    int n_compared = 0;
    integer seed = 32'h3db9;
    logic [31:0] m [0:41];
    logic [31:0] rd;
    logic [7:0] st, code;
    logic [2:0] p;
    always #12.5 mclk_in = ~mclk_in;
    tmo_mem_access #(.PROG_CYCLES(4)) dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
        .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_in(cmd), .short_cmd_in(short_cmd),
        .ctrl_region_in(ctrl_region), .page_in(page), .block_in(block), .wdata_in(wdata),
        .application_family_code_in(fam), .group_selected_in(group_selected_in), .sawn_in(sawn_in),
        .done_out(done), .rdata_out(rdata), .communication_status_byte_out(status), .selected_out(selected),
        .arb_valid_out(arb_valid), .arb_word_out(arb_word), .prog_busy_out(prog_busy));
    tmo_reader_model u_rdr (.mclk_in(mclk_in), .cmd_ready_in(cmd_ready), .done_in(done), .rdata_in(rdata),
        .status_in(status), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .short_cmd_out(short_cmd),
        .ctrl_region_out(ctrl_region), .page_out(page), .block_out(block), .wdata_out(wdata),
        .family_out(fam), .timeout_out(tmo));
    function automatic int widx(input logic ctl, input logic [2:0] pg, input logic [1:0] b);
        return 32 * ctl + 4 * pg + b;
    endfunction : widx
    function automatic logic fam_exp(input logic [7:0] rx);
        return (rx == `TMO_WILDCARD) || (rx == 8'h5a);
    endfunction : fam_exp
    task automatic results();
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic op(input tmo_pkg::tmo_cmd_t c, input logic s, input logic ctl, input logic [2:0] pg,
                      input logic [1:0] b, input logic [31:0] wd, input logic [7:0] f);
        u_rdr.issue(c, s, ctl, pg, b, wd, f, rd, st);
        if (tmo === 1'b1) begin
            fail_count++;
            results();
        end
    endtask : op
    task automatic prog(input logic ctl, input logic [2:0] pg, input logic [1:0] b, input logic [31:0] wd,
                        input logic [7:0] exp_st);
        op(tmo_pkg::TMO_CMD_PROG, 1'b0, ctl, pg, b, wd, 8'h00);
        chk("program status", {24'h0, st}, {24'h0, exp_st});
        if (exp_st == `TMO_ST_OK) begin
            m[widx(ctl, pg, b)] = wd;
        end
    endtask : prog
    task automatic rdchk(input logic ctl, input logic [2:0] pg, input logic [1:0] b);
        op(tmo_pkg::TMO_CMD_READ, 1'b0, ctl, pg, b, 32'h0, 8'h00);
        chk("read status", {24'h0, st}, {24'h0, `TMO_ST_OK});
        chk("read data", rd, m[widx(ctl, pg, b)]);
    endtask : rdchk
    initial begin
        repeat (100000) @(posedge mclk_in);
        fail_count++;
        results();
    end
    initial begin
        repeat (12) @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        // page 7 borders the identifier page during arbitration, second page is random
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 3'h7 : 3'($unsigned($random(seed)) % 7);
            for (int b = 0; b < 4; b++) prog(1'b0, p, 2'(b), $random(seed) & 32'h7fffffff, `TMO_ST_OK);
            for (int b = 0; b < 4; b++) rdchk(1'b0, p, 2'(b));
        end
        prog(1'b0, 3'h7, 2'h3, m[31] | 32'h80000000, `TMO_ST_OK);
        prog(1'b0, 3'h7, 2'h0, $random(seed), `TMO_ST_LOCKED);
        rdchk(1'b0, 3'h7, 2'h0);
        rdchk(1'b0, 3'h7, 2'h3);
        prog(1'b0, p, 2'h1, $random(seed), `TMO_ST_OK);
        rdchk(1'b0, p, 2'h1);
        // a low enable in mid program freezes the wait count and the busy flag
        fork
            prog(1'b0, p, 2'h2, $random(seed) & 32'h7fffffff, `TMO_ST_OK);
            begin
                repeat (3) @(negedge mclk_in);
                ce_in = 1'b0;
                repeat (4) begin
                    @(negedge mclk_in);
                    chk("frozen busy", {31'h0, prog_busy}, 32'h1);
                    chk("frozen done", {31'h0, done}, 32'h0);
                end
                ce_in = 1'b1;
            end
        join
        rdchk(1'b0, p, 2'h2);
        for (int b = 0; b < 3; b++) prog(1'b1, `TMO_ID_PAGE, 2'(b), $random(seed), `TMO_ST_OK);
        prog(1'b1, `TMO_ID_PAGE, `TMO_FMT_BLOCK, 32'h00005a3c, `TMO_ST_OK);
        op(tmo_pkg::TMO_CMD_READ, 1'b1, 1'b0, 3'h5, `TMO_ID_MSB_BLOCK, 32'h0, 8'h00);
        chk("short read", rd, m[34]);
        op(tmo_pkg::TMO_CMD_READ, 1'b1, 1'b0, 3'h6, `TMO_FMT_BLOCK, 32'h0, 8'h00);
        chk("format code", {24'h0, rd[7:0]}, 32'h3c);
        for (int i = 0; i < 4; i++) begin
            code = (i == 0) ? 8'h5a : (i == 1) ? `TMO_WILDCARD : (i == 2) ? 8'h11 : 8'($random(seed));
            op(tmo_pkg::TMO_CMD_FAM, 1'b1, 1'b0, 3'h0, 2'h0, 32'h0, code);
            chk("selected", {31'h0, selected}, {31'h0, fam_exp(code)});
        end
        // arbitration opens at the format code, then each command addresses the next word down into user page 7
        for (int i = 0; i < 5; i++) begin
            op(tmo_pkg::TMO_CMD_ARB, (i == 0), (i < 4), (i < 4) ? 3'h0 : 3'h7, 2'(3 - i), 32'h0, 8'h00);
            chk("arb valid", {31'h0, arb_valid}, 32'h1);
            chk("arb word", arb_word, m[35 - i]);
        end
        @(negedge mclk_in);
        group_selected_in = 1'b0;
        op(tmo_pkg::TMO_CMD_ARB, 1'b1, 1'b0, 3'h0, 2'h3, 32'h0, 8'h00);
        chk("arb unselected", {31'h0, arb_valid}, 32'h0);
        rdchk(1'b0, p, 2'h0);
        @(negedge mclk_in);
        group_selected_in = 1'b1;
        prog(1'b1, `TMO_ID_PAGE, `TMO_LOCK_BLOCK, m[35] | 32'h80000000, `TMO_ST_OK);
        prog(1'b1, `TMO_ID_PAGE, 2'h1, $random(seed), `TMO_ST_LOCKED);
        rdchk(1'b1, `TMO_ID_PAGE, 2'h1);
        prog(1'b1, `TMO_MFR_PAGE, 2'h0, $random(seed), `TMO_ST_OK);
        prog(1'b1, `TMO_MFR_PAGE, 2'h1, $random(seed), `TMO_ST_OK);
        @(negedge mclk_in);
        sawn_in = 1'b1;
        prog(1'b1, `TMO_MFR_PAGE, 2'h1, $random(seed), `TMO_ST_LOCKED);
        rdchk(1'b1, `TMO_MFR_PAGE, 2'h1);
        op(tmo_pkg::TMO_CMD_READ, 1'b0, 1'b1, `TMO_MFR_PAGE, 2'h2, 32'h0, 8'h00);
        chk("beyond control", {24'h0, st}, {24'h0, `TMO_ST_BADADDR});
        prog(1'b1, 3'h3, 2'h0, $random(seed), `TMO_ST_BADADDR);
        results();
    end
endmodule : tb_tmo_mem_access
`default_nettype wire
